// ===== logic/ccr_pkg.sv
/*
 * Package for the clock configuration register bank: offsets, fields,
 * reset values and carrier types.
 * Assumes a 32-bit APB slave; each of the three port registers takes one aligned word.
 */
package ccr_pkg;

  // ****************
  // Register indices
  // ****************
  localparam logic [6:0] CCR_IDX_PART = 7'h01;
  localparam logic [6:0] CCR_IDX_CLK = 7'h02;
  localparam logic [6:0] CCR_IDX_MINPW = 7'h03;
  localparam logic [6:0] CCR_IDX_ODLY = 7'h04;
  localparam logic [6:0] CCR_IDX_PSR = 7'h05;
  localparam logic [6:0] CCR_IDX_DSC_H = 7'h06;
  localparam logic [6:0] CCR_IDX_DSC_M = 7'h07;
  localparam logic [6:0] CCR_IDX_DSC_L = 7'h08;
  localparam logic [6:0] CCR_IDX_DRS_H = 7'h09;
  localparam logic [6:0] CCR_IDX_DRS_M = 7'h0a;
  localparam logic [6:0] CCR_IDX_DRS_L = 7'h0b;
  localparam logic [6:0] CCR_IDX_LAST = 7'h0b;
  localparam int CCR_NUM_RW = 6;

  // ****************
  // APB byte addresses of the access port
  // ****************
  localparam logic [7:0] CCR_ADDR_CTRL = 8'h00;
  localparam logic [7:0] CCR_ADDR_DATA = 8'h04;
  localparam logic [7:0] CCR_ADDR_PTR = 8'h08;

  // ****************
  // Fields
  // ****************
  localparam int CCR_CTL_AUTO_INCREMENT_FLAG = 7;
  localparam int CCR_CLK_SYSEN = 7;
  localparam int CCR_CLK_SYSDIV_LO = 5;
  localparam int CCR_CLK_MODDIV_LO = 3;
  localparam int CCR_CLK_XTALPD = 2;
  localparam int CCR_CLK_PDLVL = 1;
  localparam int CCR_CLK_GPD = 0;

  // ****************
  // Reset values and write masks
  // ****************
  localparam logic [6:0] CCR_PTR_RST = 7'h01;
  localparam logic CCR_AUTO_INCREMENT_FLAG_RST = 1'b1;
  localparam logic [7:0] CCR_CLK_RST = 8'h81;
  localparam logic [7:0] CCR_RW_RST = 8'h00;
  localparam logic [7:0] CCR_RW_MASK_MINPW = 8'hdf;
  localparam logic [7:0] CCR_RW_MASK_PSR = 8'he7;
  localparam logic [7:0] CCR_RW_MASK_DSC_H = 8'h77;
  localparam logic [7:0] CCR_RW_MASK_FULL = 8'hff;

  // Arbitrary neutral identity codes
  localparam logic [3:0] CCR_PART_CODE = 4'h5;
  localparam logic [3:0] CCR_REVISION_CODE = 4'h2;

  // ****************
  // Types
  // ****************
  typedef logic [7:0] ccr_byte_t;

  typedef struct packed {
    logic system_clock_output_en;
    logic [1:0] sys_div;
    logic [1:0] mod_div;
    logic xtal_pd;
    logic pd_level;
    logic global_pd;
  } ccr_clk_cfg_s;

  typedef enum logic [1:0] {
    CCR_DIV1 = 2'b00,
    CCR_DIV2 = 2'b01,
    CCR_DIV4 = 2'b10,
    CCR_DIV8 = 2'b11
  } ccr_div_e;

endpackage : ccr_pkg

// ===== logic/ccr_clk_div.sv
/*
 * Divider producing a one-cycle enable pulse per divided period.
 * Assumes the caller selects the ratio as a 2-bit power-of-two code.
 */
`timescale 1ns/1ns
module ccr_clk_div
  import ccr_pkg::*;
(
  input wire logic system_clock_output_i,
  input wire logic reset_n_i,
  input wire logic run_i,
  input wire ccr_div_e div_i,
  output logic tick_o
);

  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic [2:0] lim;

  // ****************
  // Terminal count
  // ****************
  always_comb begin
    case (div_i)
      CCR_DIV1: lim = 3'h0;
      CCR_DIV2: lim = 3'h1;
      CCR_DIV4: lim = 3'h3;
      CCR_DIV8: lim = 3'h7;
      default: lim = 3'h0;
    endcase
    if (!run_i || cnt_q >= lim) begin
      cnt_d = 3'h0;
    end else begin
      cnt_d = cnt_q + 3'h1;
    end
    tick_o = run_i && (cnt_q >= lim);
  end

  always_ff @(posedge system_clock_output_i) begin
    if (!reset_n_i) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : ccr_clk_div

// ===== logic/ccr_regs.sv
/*
 * Control-port register bank with address pointer, part/revision register
 * and clock configuration, reached over APB.
 * Assumes one clock system_clock_output_i; the quiet strap pin is asynchronous.
 */
//
// Functional notes
// - All registers read/write except part/revision and decimator results.
// - Control byte: bit 7 auto-increment, bits 6:0 address; pointer resets to 01.
// - With auto-increment set, pointer advances after each data-port access; else holds.
// - Register 01h: part code high nibble, revision code low nibble, read-only.
// - Register 02h: output enable, system divider, modulator divider, power bits.
// - System clock output enable defaults to 1; clearing disables the driver.
// - System divider: 00 strapped, 01 by 2, 10 by 4, 11 by 8.
// - During reset, quiet strap low means divide by 1, high by 2.
// - Strap captured at reset release; pin then is normal quiet control.
// - Modulator divider defaults 00: divide by 1, 2, 4 or 8.
// - Crystal power-down defaults 0; setting 1 stops the oscillator.
// - Global power-down defaults 1; software clears it for operation.
`timescale 1ns/1ns
module ccr_regs
  import ccr_pkg::*;
(
  input wire logic system_clock_output_i,
  input wire logic reset_n_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic quiet_strap_i,
  input wire logic [23:0] dec_result_i,
  output logic quiet_o,
  output logic system_clock_output_o,
  output logic system_clock_output_oe_o,
  output logic modulator_clock_en_o,
  output logic crystal_power_down_o,
  output logic power_down_output_level_o,
  output logic global_power_down_o
);

  // ****************
  // Strap synchroniser
  // ****************
  logic [2:0] strap_sync_q;
  logic [2:0] strap_sync_d;
  logic quiet_q;
  logic quiet_d;
  logic strap_div2_q;
  logic strap_div2_d;
  logic in_reset_q;
  logic in_reset_d;

  always_comb begin
    strap_sync_d = {strap_sync_q[1:0], quiet_strap_i};
    quiet_d = quiet_q;
    if (strap_sync_q[2] == strap_sync_q[1]) begin
      quiet_d = strap_sync_q[2];
    end
    strap_div2_d = strap_div2_q;
    if (in_reset_q) begin
      strap_div2_d = quiet_d;
    end
    in_reset_d = 1'b0;
  end

  always_ff @(posedge system_clock_output_i) begin
    strap_sync_q <= strap_sync_d;
    quiet_q <= quiet_d;
    if (!reset_n_i) begin
      in_reset_q <= 1'b1;
      strap_div2_q <= strap_div2_d;
    end else begin
      in_reset_q <= in_reset_d;
      strap_div2_q <= strap_div2_d;
    end
  end

  assign quiet_o = quiet_q;

  // ****************
  // Pointer and registers
  // ****************
  logic [6:0] ptr_q;
  logic [6:0] ptr_d;
  logic auto_increment_flag_q;
  logic auto_increment_flag_d;
  ccr_clk_cfg_s cfg_q;
  ccr_clk_cfg_s cfg_d;
  ccr_byte_t rw_q [CCR_NUM_RW];
  ccr_byte_t rw_d [CCR_NUM_RW];
  ccr_byte_t rw_mask [CCR_NUM_RW];
  logic [CCR_NUM_RW-1:0] rw_hit;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic acc;
  logic wr_data;
  logic rd_data;
  logic adv;
  ccr_byte_t wbyte;
  ccr_byte_t cur;

  assign rw_mask[0] = CCR_RW_MASK_MINPW;
  assign rw_mask[1] = CCR_RW_MASK_FULL;
  assign rw_mask[2] = CCR_RW_MASK_PSR;
  assign rw_mask[3] = CCR_RW_MASK_DSC_H;
  assign rw_mask[4] = CCR_RW_MASK_FULL;
  assign rw_mask[5] = CCR_RW_MASK_FULL;

  assign acc = psel && penable;
  assign wbyte = pwdata[7:0];
  assign wr_data = acc && pwrite && (paddr == CCR_ADDR_DATA);
  assign rd_data = acc && !pwrite && (paddr == CCR_ADDR_DATA);
  assign adv = (wr_data || rd_data) && auto_increment_flag_q;

  genvar gi;
  generate
    for (gi = 0; gi < CCR_NUM_RW; gi++) begin : g_rw
      always_comb begin
        rw_hit[gi] = (ptr_q == CCR_IDX_MINPW + 7'(gi));
        rw_d[gi] = rw_q[gi];
        if (wr_data && rw_hit[gi]) begin
          rw_d[gi] = wbyte & rw_mask[gi];
        end
      end
      always_ff @(posedge system_clock_output_i) begin
        if (!reset_n_i) begin
          rw_q[gi] <= CCR_RW_RST;
        end else begin
          rw_q[gi] <= rw_d[gi];
        end
      end
    end
  endgenerate

  always_comb begin
    cur = 8'h00;
    case (ptr_q)
      CCR_IDX_PART: cur = {CCR_PART_CODE, CCR_REVISION_CODE};
      CCR_IDX_CLK: cur = cfg_q;
      CCR_IDX_DRS_H: cur = dec_result_i[23:16];
      CCR_IDX_DRS_M: cur = dec_result_i[15:8];
      CCR_IDX_DRS_L: cur = dec_result_i[7:0];
      default: begin
        for (int i = 0; i < CCR_NUM_RW; i++) begin
          if (rw_hit[i]) begin
            cur = rw_q[i];
          end
        end
      end
    endcase
  end

  always_comb begin
    ptr_d = ptr_q;
    auto_increment_flag_d = auto_increment_flag_q;
    cfg_d = cfg_q;
    rdata_d = rdata_q;
    if (acc && pwrite && paddr == CCR_ADDR_CTRL) begin
      auto_increment_flag_d = wbyte[CCR_CTL_AUTO_INCREMENT_FLAG];
      ptr_d = wbyte[6:0];
    end
    if (wr_data && ptr_q == CCR_IDX_CLK) begin
      cfg_d = wbyte;
    end
    if (adv) begin
      ptr_d = ptr_q + 7'h01;
    end
    if (psel && !penable && !pwrite) begin
      case (paddr)
        CCR_ADDR_CTRL: rdata_d = {24'h0, auto_increment_flag_q, ptr_q};
        CCR_ADDR_DATA: rdata_d = {24'h0, cur};
        CCR_ADDR_PTR: rdata_d = {25'h0, ptr_q};
        default: rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge system_clock_output_i) begin
    if (!reset_n_i) begin
      ptr_q <= CCR_PTR_RST;
      auto_increment_flag_q <= CCR_AUTO_INCREMENT_FLAG_RST;
      cfg_q <= CCR_CLK_RST;
      rdata_q <= 32'h0;
    end else begin
      ptr_q <= ptr_d;
      auto_increment_flag_q <= auto_increment_flag_d;
      cfg_q <= cfg_d;
      rdata_q <= rdata_d;
    end
  end

  // ****************
  // APB answers
  // ****************
  assign pready = 1'b1;
  assign prdata = rdata_q;
  assign pslverr = acc && !(paddr == CCR_ADDR_CTRL || paddr == CCR_ADDR_DATA ||
                            paddr == CCR_ADDR_PTR);

  // ****************
  // Clock outputs
  // ****************
  ccr_div_e sys_sel;
  logic sys_tick;
  logic sys_out_q;
  logic sys_out_d;

  always_comb begin
    sys_sel = ccr_div_e'(cfg_q.sys_div);
    if (cfg_q.sys_div == CCR_DIV1) begin
      sys_sel = strap_div2_q ? CCR_DIV2 : CCR_DIV1;
    end
    sys_out_d = sys_out_q;
    if (sys_tick) begin
      sys_out_d = !sys_out_q;
    end
  end

  ccr_clk_div u_sys_div (
    .system_clock_output_i(system_clock_output_i),
    .reset_n_i(reset_n_i),
    .run_i(!cfg_q.xtal_pd),
    .div_i(sys_sel),
    .tick_o(sys_tick)
  );

  ccr_clk_div u_mod_div (
    .system_clock_output_i(system_clock_output_i),
    .reset_n_i(reset_n_i),
    .run_i(!cfg_q.xtal_pd && !cfg_q.global_pd),
    .div_i(ccr_div_e'(cfg_q.mod_div)),
    .tick_o(modulator_clock_en_o)
  );

  always_ff @(posedge system_clock_output_i) begin
    if (!reset_n_i) begin
      sys_out_q <= 1'b0;
    end else begin
      sys_out_q <= sys_out_d;
    end
  end

  assign system_clock_output_o = sys_out_q;
  assign system_clock_output_oe_o = cfg_q.system_clock_output_en;
  assign crystal_power_down_o = cfg_q.xtal_pd;
  assign power_down_output_level_o = cfg_q.pd_level;
  assign global_power_down_o = cfg_q.global_pd;

endmodule : ccr_regs

// ===== sim/ccr_regs_assertions.sv
/* Port checker for ccr_regs.
   Assumes the bind below and the 0x00/0x04/0x08 port map. */
`timescale 1ns/1ns
module ccr_regs_chk (
  input wire logic system_clock_output_i,
  input wire logic reset_n_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic system_clock_output_o,
  input wire logic system_clock_output_oe_o,
  input wire logic crystal_power_down_o,
  input wire logic power_down_output_level_o,
  input wire logic global_power_down_o
);
  // ****
  // Properties
  // ****
  default clocking @(posedge system_clock_output_i); endclocking
  default disable iff (!reset_n_i);
  wire acc = psel && penable;
  wire dwr = acc && pwrite && paddr == 8'h04;
  property p_rst;
    $rose(reset_n_i) |-> system_clock_output_oe_o && global_power_down_o
      && !crystal_power_down_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  property p_oe; $changed(system_clock_output_oe_o) |-> $past(dwr); endproperty
  a_oe: assert property (p_oe) else $error("enable moved without write");
  property p_xpd; $changed(crystal_power_down_o) |-> $past(dwr); endproperty
  a_xpd: assert property (p_xpd) else $error("crystal bit moved without write");
  property p_gpd; $changed(global_power_down_o) |-> $past(dwr); endproperty
  a_gpd: assert property (p_gpd) else $error("power bit moved without write");
  property p_lvl; $changed(power_down_output_level_o) |-> $past(dwr); endproperty
  a_lvl: assert property (p_lvl) else $error("level bit moved without write");
  property p_ptr;
    acc && pwrite && paddr == 8'h00 ##2 psel && !pwrite && paddr == 8'h08 ##1 penable
      |-> prdata == {25'h0, $past(pwdata[6:0], 3)};
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer readback wrong");
  property p_xs; crystal_power_down_o [*3] |-> $stable(system_clock_output_o); endproperty
  a_xs: assert property (p_xs) else $error("clock runs in crystal power-down");
  property p_err; acc && paddr > 8'h08 |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("unmapped access accepted");
  c_wr: cover property (dwr);
  c_err: cover property (pslverr);
  c_rst: cover property ($rose(reset_n_i));
endmodule : ccr_regs_chk
bind ccr_regs ccr_regs_chk u_chk (.system_clock_output_i(system_clock_output_i), .reset_n_i(reset_n_i), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pslverr(pslverr), .system_clock_output_o(system_clock_output_o),
  .system_clock_output_oe_o(system_clock_output_oe_o),
  .crystal_power_down_o(crystal_power_down_o),
  .power_down_output_level_o(power_down_output_level_o),
  .global_power_down_o(global_power_down_o));

// ===== sim/ccr_host.sv
/* Host model: APB master of the control port.
   Assumes a slave that may add wait states. */
`timescale 1ns/1ns
module ccr_host (
  input wire logic system_clock_output_i,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [7:0] paddr_o,
  output logic [31:0] pwdata_o
);
  // ****
  // Transfers
  // ****
  initial {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge system_clock_output_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge system_clock_output_i);
    penable_o <= 1'b1;
    do @(posedge system_clock_output_i); while (pready_i !== 1'b1);
    r = prdata_i;
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask : xfer
  task automatic ctl(input logic inc, input logic [6:0] p);
    logic [31:0] r;
    logic e;
    xfer(1'b1, 8'h00, {24'h0, inc, p}, r, e);
  endtask : ctl
endmodule : ccr_host

// ===== sim/testbench.sv
/* Self-checking bench for ccr_regs.
   Assumes ccr_host as control-port master. */
`timescale 1ns/1ns
module testbench
  import ccr_pkg::*;
;
  // ****
  // Bench
  // ****
  logic system_clock_output = 1'b0;
  logic reset_n = 1'b0;
  logic strap = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, sco, oe, mce, xpd, lvl, gpd, er, qo;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int n_fail = 0;
  int cmp_count = 0;
  always #5 system_clock_output = ~system_clock_output;
  ccr_host i_host (.system_clock_output_i(system_clock_output), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata));
  ccr_regs i_dut (.system_clock_output_i(system_clock_output), .reset_n_i(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .quiet_strap_i(strap), .dec_result_i(24'ha5c33c), .quiet_o(qo),
    .system_clock_output_o(sco), .system_clock_output_oe_o(oe), .modulator_clock_en_o(mce),
    .crystal_power_down_o(xpd), .power_down_output_level_o(lvl), .global_power_down_o(gpd));
  task automatic cmp(input string n, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", n, x, g);
    end
  endtask : cmp
  task automatic pins(input logic [3:0] x);
    @(negedge system_clock_output);
    cmp("pins", {28'h0, x}, {28'h0, oe, xpd, lvl, gpd});
  endtask : pins
  task automatic rg(input logic [7:0] a);
    i_host.xfer(1'b0, a, 32'h0, rd, er);
  endtask : rg
  task automatic wr(input logic [7:0] d);
    i_host.xfer(1'b1, CCR_ADDR_DATA, {24'h0, d}, rd, er);
  endtask : wr
  task automatic t_defaults;
    rg(CCR_ADDR_PTR);
    cmp("pointer", 32'h1, rd);
    rg(CCR_ADDR_DATA);
    cmp("part", {24'h0, CCR_PART_CODE, CCR_REVISION_CODE}, rd);
    rg(CCR_ADDR_DATA);
    cmp("config", 32'h81, rd);
    rg(CCR_ADDR_PTR);
    cmp("pointer", 32'h3, rd);
    pins(4'b1001);
  endtask : t_defaults
  task automatic t_cfg;
    i_host.ctl(1'b1, CCR_IDX_CLK);
    wr(8'h46);
    pins(4'b0110);
    i_host.ctl(1'b0, CCR_IDX_CLK);
    rg(CCR_ADDR_PTR);
    cmp("pointer", 32'h2, rd);
    repeat (2) rg(CCR_ADDR_DATA);
    cmp("config", 32'h46, rd);
    rg(CCR_ADDR_PTR);
    cmp("pointer", 32'h2, rd);
  endtask : t_cfg
  task automatic t_ro;
    i_host.ctl(1'b1, CCR_IDX_PART);
    wr(8'hff);
    rg(CCR_ADDR_PTR);
    cmp("pointer", 32'h2, rd);
    i_host.ctl(1'b0, CCR_IDX_PART);
    rg(CCR_ADDR_DATA);
    cmp("part kept", {24'h0, CCR_PART_CODE, CCR_REVISION_CODE}, rd);
    i_host.ctl(1'b1, CCR_IDX_MINPW);
    wr(8'hff);
    wr(8'hff);
    i_host.ctl(1'b1, CCR_IDX_MINPW);
    rg(CCR_ADDR_DATA);
    cmp("masked", {24'h0, CCR_RW_MASK_MINPW}, rd);
    rg(CCR_ADDR_DATA);
    cmp("full", 32'hff, rd);
    i_host.ctl(1'b0, CCR_IDX_DRS_H);
    wr(8'h00);
    rg(CCR_ADDR_DATA);
    cmp("result", 32'ha5, rd);
    i_host.xfer(1'b1, 8'h0c, 32'h0, rd, er);
    cmp("slave error", 32'h1, {31'h0, er});
  endtask : t_ro
  task automatic t_div(input int s0);
    int ns, nm;
    logic p;
    for (int k = 0; k < 4; k++) begin
      i_host.ctl(1'b1, CCR_IDX_CLK);
      wr({1'b1, k[1:0], k[1:0], 3'b000});
      repeat (4) @(negedge system_clock_output);
      ns = 0;
      nm = 0;
      p = sco;
      repeat (16) begin
        @(negedge system_clock_output);
        ns += int'(sco !== p);
        nm += int'(mce === 1'b1);
        p = sco;
      end
      cmp("clock toggles", (k == 0) ? s0 : 16 >> k, ns);
      cmp("modulator ticks", 16 >> k, nm);
    end
  endtask : t_div
  task automatic t_strap;
    @(posedge system_clock_output);
    strap <= 1'b1;
    reset_n <= 1'b0;
    repeat (5) @(posedge system_clock_output);
    reset_n <= 1'b1;
    @(posedge system_clock_output);
    strap <= 1'b0;
    @(negedge system_clock_output);
    cmp("quiet high", 32'h1, {31'h0, qo});
    t_div(8);
    cmp("quiet low", 32'h0, {31'h0, qo});
  endtask : t_strap
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  initial begin
    repeat (3) @(posedge system_clock_output);
    reset_n <= 1'b1;
    t_defaults;
    t_cfg;
    t_ro;
    t_div(16);
    t_strap;
    complete_run;
  end
  initial begin
    #200000;
    n_fail++;
    complete_run;
  end
endmodule : testbench
